// ==== boe_pkg.sv ====
// Constants, opcodes and payload layout for the banded order executor
`default_nettype none
package boe_pkg;
  localparam logic [7:0] OP_HALT         = 8'h00;
  localparam logic [7:0] OP_BRANCH       = 8'h01;
  localparam logic [7:0] OP_SET_SLICED   = 8'h08;
  localparam logic [7:0] OP_SET_DEST_ONLY_LOGIC_CODE   = 8'h0C;
  localparam logic [7:0] OP_SET_BOOL_HD  = 8'h0D;
  localparam logic [7:0] OP_SET_BOOL_SD  = 8'h0E;
  localparam logic [7:0] OP_SET_BOOL_SHD = 8'h0F;
  localparam logic [7:0] OP_DEST_FILL    = 8'h30;
  // Opcode groups, taken from opcode bits 7:3
  localparam logic [4:0] GRP_SETUP    = 5'h01;
  localparam logic [4:0] GRP_FRAME    = 5'h02;
  localparam logic [4:0] GRP_UNBANDED = 5'h04;
  localparam logic [4:0] GRP_SLICED   = 5'h06;
  // Render kinds, taken from opcode bits 2:0
  localparam logic [2:0] KIND_D      = 3'h0;
  localparam logic [2:0] KIND_BAD    = 3'h1;
  localparam logic [2:0] KIND_SD     = 3'h2;
  localparam logic [2:0] KIND_SHD    = 3'h3;
  localparam logic [2:0] KIND_SL_D   = 3'h4;
  localparam logic [2:0] KIND_SL_HD  = 3'h5;
  localparam logic [2:0] KIND_X_D    = 3'h6;
  localparam logic [2:0] KIND_X_HD   = 3'h7;
  // Flags word of the sliced map setup order
  localparam int unsigned FLAG_REVERSE_BIT = 0;
  // Write-back word indices within the destination fill order
  localparam logic [3:0] WB_IDX_HEAD  = 4'h0;
  localparam logic [3:0] WB_IDX_DA_HI = 4'h1;
  localparam logic [3:0] WB_IDX_DA_LO = 4'h2;
  localparam logic [3:0] WB_IDX_FH    = 4'h4;
  localparam logic [7:0] RST_LOGIC_CODE = 8'h00;
  localparam int unsigned ARG_WORDS = 7;

  // Payload words that follow the opcode word
  function automatic logic [3:0] payloadLen(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op == OP_HALT) n = 4'h0;
    else if (op == OP_BRANCH) n = 4'h2;
    else if (op == OP_SET_SLICED) n = 4'h7;
    else if (op[7:3] == GRP_SETUP) n = (op[2]) ? 4'h1 : 4'h4;
    else begin
      case (op[2:0])
        KIND_D, KIND_SL_D: n = 4'h4;
        KIND_SD:           n = 4'h6;
        KIND_SHD:          n = 4'h9;
        KIND_SL_HD:        n = 4'h7;
        KIND_X_D:          n = 4'h8;
        default:           n = 4'hB;
      endcase
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// ==== banded_order_executor.sv ====
// Display-list order executor for banded bitmaps, with its input word FIFO
`default_nettype none
module boe_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         flush,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] memReg [DEPTH];
  logic [AW-1:0] wrReg, wrNext, rdReg, rdNext;
  logic [AW:0]   cntReg, cntNext;
  logic          push, pop;

  assign inReady  = (cntReg != (AW+1)'(DEPTH));
  assign outValid = (cntReg != '0);
  assign outData  = memReg[rdReg];
  assign push     = inValid && inReady && !flush;
  assign pop      = outValid && outReady && !flush;

  always_comb begin
    wrNext  = push ? AW'(wrReg + 1'b1) : wrReg;
    rdNext  = pop ? AW'(rdReg + 1'b1) : rdReg;
    cntNext = (AW+1)'(cntReg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (flush) begin
      wrNext  = '0;
      rdNext  = '0;
      cntNext = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrReg  <= '0;
      rdReg  <= '0;
      cntReg <= '0;
    end else begin
      wrReg  <= wrNext;
      rdReg  <= rdNext;
      cntReg <= cntNext;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) memReg[wrReg] <= inData;
  end
endmodule

// How it works
// RULE1: Software gives bottom-left frame addresses when reversed.
// RULE2: Reversed halftone remainder counts up to top.
// RULE3: Reversed mode walks tables last entry first.
// RULE4: Reversed scanline address is past final run.
// RULE5: Reversed table pointer names last word.
// RULE6: Reversed halftone operands refer to image end.
// RULE7: Frame and unbanded orders always render downward.
// RULE8: Run sliced order only when slice matches band.
// RULE9: Software numbers slices rising top to bottom.
// RULE10: Band crossing stops transfer, then updates order.
// RULE11: Written-back values resume at next band edge.
// RULE12: Fault steps slice up, or down when reversed.
// RULE13: Faults arise only from sliced-target orders.
// RULE14: Unused source or halftone is neither fetched nor updated.
// RULE15: Decode halt, branch and setup opcodes.
// RULE16: Decode frame, unbanded and sliced order groups.
// RULE17: Destination fill: opcode, slice, address, width, height.
// RULE18: Fill uses destination-only logic code.
// RULE19: Physical address is logical plus map offset.
// RULE20: Software starts frames inside the bitmap.
// RULE21: Row pitch comes from the sliced map setup.
// RULE22: Fault writes slice, next-band address, remaining height.
// RULE23: Halt ends the list; branch redirects it.
// RULE24: After write-back, fetch the next order.
module banded_order_executor
  import boe_pkg::*;
#(
  parameter int unsigned ADDR_W     = 28,
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // List control
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] startAddr,
  input  wire logic [7:0]        curBand,
  output logic                   running,
  output logic                   haltPulse,
  output logic                   branchPulse,
  output logic [ADDR_W-1:0]      fetchAddr,
  // Display-list words from memory
  input  wire logic              listValid,
  output logic                   listReady,
  input  wire logic [15:0]       listData,
  // Destination rows to the datapath
  output logic                   rowValid,
  input  wire logic              rowReady,
  output logic [31:0]            rowAddr,
  output logic [15:0]            rowWidth,
  output logic [7:0]             rowLogic,
  // Other render orders to the datapath
  output logic                   dispValid,
  output logic [7:0]             dispOpcode,
  output logic                   dispReverse,
  output logic                   dispWalkBack,
  output logic                   dispNeedSrc,
  output logic                   dispNeedHt,
  // Write-back into the display list
  output logic                   wbValid,
  input  wire logic              wbReady,
  output logic [ADDR_W-1:0]      wbAddr,
  output logic [15:0]            wbData,
  // Status
  output logic                   bandFault,
  output logic                   orderSkipped,
  output logic                   badOpcode
);
  import boe_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_ARGS, ST_DO, ST_ROWS, ST_WB} boe_state_t;
  boe_state_t stateReg, stateNext;
  logic [ADDR_W-1:0] posReg, posNext, orderReg, orderNext;
  logic [7:0]  opReg, opNext, sliceReg, sliceNext;
  logic [3:0]  argCntReg, argCntNext, wbIdxReg, wbIdxNext;
  logic [16*ARG_WORDS-1:0] argReg, argNext;
  logic [31:0] offsetReg, offsetNext, pitchReg, pitchNext, spanReg, spanNext;
  logic [31:0] physReg, physNext, logReg, logNext;
  logic [15:0] widthReg, widthNext, leftReg, leftNext;
  logic [7:0]  boolD, boolDN, boolHD, boolHDN, boolSD, boolSDN, boolSHD, boolSHDN;
  logic        revReg, revNext, haltReg, haltNext, brReg, brNext, faultReg, faultNext;
  logic        skipReg, skipNext, badReg, badNext, dispReg, dispNext;
  logic        flush, qValid, qReady, sliceHit, crossing;
  logic [15:0] qData;
  logic [31:0] stepPhys, stepLog;

  boe_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) boe_fifo_i (
    .mclk(mclk), .rst(rst), .flush(flush),
    .inValid(listValid), .inReady(listReady), .inData(listData),
    .outValid(qValid), .outReady(qReady), .outData(qData)
  );

  function automatic logic dependsHi(input logic [7:0] code, input logic three);
    return three ? (code[7:4] != code[3:0]) : (code[3:2] != code[1:0]);
  endfunction

  function automatic logic dependsMid(input logic [7:0] code);
    return {code[7:6], code[3:2]} != {code[5:4], code[1:0]};
  endfunction

  assign running   = (stateReg != ST_IDLE);
  // Stale words still in the buffer during a restart flush must not be taken
  assign qReady    = ((stateReg == ST_OP) || (stateReg == ST_ARGS)) && !flush;
  assign flush     = brReg;
  assign fetchAddr = posReg;
  assign rowValid  = (stateReg == ST_ROWS);
  assign rowAddr   = physReg;
  assign rowWidth  = widthReg;
  assign rowLogic  = boolD; // RULE18
  assign wbValid   = (stateReg == ST_WB);
  assign haltPulse = haltReg;
  assign branchPulse  = brReg;
  assign bandFault    = faultReg;
  assign orderSkipped = skipReg;
  assign badOpcode    = badReg;
  assign dispValid    = dispReg;
  assign dispOpcode   = opReg;
  assign sliceHit     = (sliceReg == curBand); // RULE8
  assign dispReverse  = revReg && (opReg[7:3] == GRP_SLICED); // RULE7
  assign dispWalkBack = dispReverse && (opReg[2:1] == 2'b10); // RULE3
  // RULE14
  assign dispNeedSrc  = (opReg[2:0] == KIND_SD) ? dependsHi(boolSD, 1'b0) :
                        (opReg[2:0] == KIND_SHD || opReg[2:0] == KIND_X_HD) ? dependsMid(boolSHD) :
                        (opReg[2:0] == KIND_X_D);
  assign dispNeedHt   = (opReg[2:0] == KIND_SHD || opReg[2:0] == KIND_X_HD) ? dependsHi(boolSHD, 1'b1) :
                        (opReg[2:0] == KIND_SL_HD) ? dependsHi(boolHD, 1'b0) : 1'b0;
  // RULE21
  assign stepPhys = revReg ? physReg - pitchReg : physReg + pitchReg;
  assign stepLog  = revReg ? logReg - pitchReg : logReg + pitchReg;
  assign crossing = revReg ? (physReg < pitchReg) : (stepPhys >= spanReg); // RULE10

  always_comb begin
    wbData = {8'h00, leftReg[7:0]};
    case (wbIdxReg)
      WB_IDX_HEAD:  wbData = {opReg, sliceReg};
      WB_IDX_DA_HI: wbData = logReg[31:16];
      WB_IDX_DA_LO: wbData = logReg[15:0];
      default:      wbData = leftReg;
    endcase
    wbAddr = ADDR_W'(orderReg + {wbIdxReg, 1'b0});
  end

  always_comb begin
    stateNext = stateReg;
    posNext = posReg;
    orderNext = orderReg;
    opNext = opReg;
    sliceNext = sliceReg;
    argCntNext = argCntReg;
    argNext = argReg;
    wbIdxNext = wbIdxReg;
    offsetNext = offsetReg;
    pitchNext = pitchReg;
    spanNext = spanReg;
    physNext = physReg;
    logNext = logReg;
    widthNext = widthReg;
    leftNext = leftReg;
    revNext = revReg;
    boolDN = boolD;
    boolHDN = boolHD;
    boolSDN = boolSD;
    boolSHDN = boolSHD;
    haltNext = 1'b0;
    brNext = 1'b0;
    faultNext = 1'b0;
    skipNext = 1'b0;
    badNext = 1'b0;
    dispNext = 1'b0;
    if (qValid && qReady) posNext = ADDR_W'(posReg + 2'd2);
    case (stateReg)
      ST_IDLE: begin
        if (start) begin
          posNext = startAddr;
          brNext = 1'b1;
          stateNext = ST_OP;
        end
      end
      ST_OP: begin
        if (qValid && qReady) begin
          orderNext = posReg;
          opNext = qData[15:8];
          sliceNext = qData[7:0];
          argCntNext = payloadLen(qData[15:8]);
          stateNext = (payloadLen(qData[15:8]) == 4'h0) ? ST_DO : ST_ARGS;
        end
      end
      ST_ARGS: begin
        if (qValid && qReady) begin
          argNext = {argReg[16*ARG_WORDS-17:0], qData};
          argCntNext = argCntReg - 4'h1;
          if (argCntReg == 4'h1) stateNext = ST_DO;
        end
      end
      ST_DO: begin
        stateNext = ST_OP;
        if (opReg == OP_HALT) begin // RULE15
          haltNext = 1'b1; // RULE23
          stateNext = ST_IDLE;
        end else if (opReg == OP_BRANCH) begin
          posNext = argReg[ADDR_W-1:0]; // RULE23
          brNext = 1'b1;
        end else if (opReg == OP_SET_SLICED) begin
          offsetNext = argReg[111:80];
          pitchNext = argReg[79:48];
          spanNext = argReg[47:16];
          revNext = argReg[FLAG_REVERSE_BIT];
        end else if (opReg == OP_SET_DEST_ONLY_LOGIC_CODE) boolDN = argReg[7:0];
        else if (opReg == OP_SET_BOOL_HD) boolHDN = argReg[7:0];
        else if (opReg == OP_SET_BOOL_SD) boolSDN = argReg[7:0];
        else if (opReg == OP_SET_BOOL_SHD) boolSHDN = argReg[7:0];
        else if (opReg[7:3] == GRP_SETUP) begin
          stateNext = ST_OP;
        end else if (opReg == OP_DEST_FILL) begin // RULE17
          if (!sliceHit) skipNext = 1'b1; // RULE8
          else begin
            logNext = argReg[63:32];
            physNext = argReg[63:32] + offsetReg; // RULE19
            widthNext = argReg[31:16];
            leftNext = argReg[15:0];
            if (argReg[15:0] != 16'h0000) stateNext = ST_ROWS;
          end
        end else if ((opReg[7:3] == GRP_FRAME || opReg[7:3] == GRP_UNBANDED
                      || opReg[7:3] == GRP_SLICED) && opReg[2:0] != KIND_BAD) begin // RULE16
          if (opReg[7:3] == GRP_SLICED && !sliceHit) skipNext = 1'b1;
          else dispNext = 1'b1;
        end else begin
          badNext = 1'b1;
          haltNext = 1'b1;
          stateNext = ST_IDLE;
        end
      end
      ST_ROWS: begin
        if (rowReady) begin
          leftNext = leftReg - 16'h0001;
          physNext = stepPhys;
          logNext = stepLog; // RULE11
          if (leftReg == 16'h0001) stateNext = ST_OP;
          else if (crossing) begin
            faultNext = 1'b1; // RULE13
            sliceNext = revReg ? sliceReg - 8'h01 : sliceReg + 8'h01; // RULE12
            wbIdxNext = WB_IDX_HEAD;
            stateNext = ST_WB;
          end
        end
      end
      ST_WB: begin
        if (wbReady) begin // RULE22
          case (wbIdxReg)
            WB_IDX_HEAD:  wbIdxNext = WB_IDX_DA_HI;
            WB_IDX_DA_HI: wbIdxNext = WB_IDX_DA_LO;
            WB_IDX_DA_LO: wbIdxNext = WB_IDX_FH;
            default:      stateNext = ST_OP; // RULE24
          endcase
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_IDLE;
      posReg <= '0;
      orderReg <= '0;
      opReg <= '0;
      sliceReg <= '0;
      argCntReg <= '0;
      argReg <= '0;
      wbIdxReg <= '0;
      offsetReg <= '0;
      pitchReg <= '0;
      spanReg <= '0;
      physReg <= '0;
      logReg <= '0;
      widthReg <= '0;
      leftReg <= '0;
      revReg <= 1'b0;
      boolD <= RST_LOGIC_CODE;
      boolHD <= RST_LOGIC_CODE;
      boolSD <= RST_LOGIC_CODE;
      boolSHD <= RST_LOGIC_CODE;
      {haltReg, brReg, faultReg, skipReg, badReg, dispReg} <= '0;
    end else begin
      stateReg <= stateNext;
      posReg <= posNext;
      orderReg <= orderNext;
      opReg <= opNext;
      sliceReg <= sliceNext;
      argCntReg <= argCntNext;
      argReg <= argNext;
      wbIdxReg <= wbIdxNext;
      offsetReg <= offsetNext;
      pitchReg <= pitchNext;
      spanReg <= spanNext;
      physReg <= physNext;
      logReg <= logNext;
      widthReg <= widthNext;
      leftReg <= leftNext;
      revReg <= revNext;
      boolD <= boolDN;
      boolHD <= boolHDN;
      boolSD <= boolSDN;
      boolSHD <= boolSHDN;
      {haltReg, brReg, faultReg, skipReg, badReg, dispReg} <=
        {haltNext, brNext, faultNext, skipNext, badNext, dispNext};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_slice_gate;
    (stateReg == ST_DO && opReg == OP_DEST_FILL && !sliceHit) |=> orderSkipped && !rowValid;
  endproperty
  a_slice_gate: assert property (p_slice_gate) else $error("mismatched slice was executed"); // RULE8
  property p_slice_step;
    bandFault |-> sliceReg == ($past(revReg) ? 8'($past(sliceReg) - 8'h01) : 8'($past(sliceReg) + 8'h01));
  endproperty
  a_slice_step: assert property (p_slice_step) else $error("slice not stepped on fault"); // RULE12
  property p_fault_early;
    bandFault |-> wbValid && leftReg != 16'h0000 && wbIdxReg == WB_IDX_HEAD;
  endproperty
  a_fault_early: assert property (p_fault_early) else $error("fault without early stop"); // RULE10
  property p_fault_sliced;
    bandFault |-> opReg == OP_DEST_FILL;
  endproperty
  a_fault_sliced: assert property (p_fault_sliced) else $error("fault from non-sliced order"); // RULE13
  property p_phys_addr;
    $rose(rowValid) |-> rowAddr == 32'(logReg + offsetReg);
  endproperty
  a_phys_addr: assert property (p_phys_addr) else $error("physical address wrong"); // RULE19
  property p_pitch_step;
    (rowValid && rowReady && leftReg > 16'h0001) |=> rowAddr == 32'($past(revReg) ?
      $past(rowAddr) - pitchReg : $past(rowAddr) + pitchReg);
  endproperty
  a_pitch_step: assert property (p_pitch_step) else $error("row step not one pitch"); // RULE21
  property p_wb_height;
    (wbValid && wbIdxReg == WB_IDX_FH) |-> wbData == leftReg && wbAddr == ADDR_W'(orderReg + 4'h8);
  endproperty
  a_wb_height: assert property (p_wb_height) else $error("height write-back wrong"); // RULE22
  property p_wb_resume;
    (wbValid && wbReady && wbIdxReg == WB_IDX_FH) |=> stateReg == ST_OP ##1 !wbValid;
  endproperty
  a_wb_resume: assert property (p_wb_resume) else $error("no fetch after write-back"); // RULE24
  property p_down_only;
    (dispValid && dispOpcode[7:3] != GRP_SLICED) |-> !dispReverse && !dispWalkBack;
  endproperty
  a_down_only: assert property (p_down_only) else $error("reverse on non-sliced order"); // RULE7
  property p_halt_stop;
    haltPulse |-> !running ##1 !running || $past(start);
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop"); // RULE23

  c_fault: cover property (bandFault ##[1:8] (wbValid && wbReady && wbIdxReg == WB_IDX_FH));
  c_halt: cover property (haltPulse);
  c_branch: cover property (running && branchPulse);
  c_skip: cover property (orderSkipped);
endmodule
`default_nettype wire

// ==== boe_mem_model.sv ====
// Shared-memory model of the display list feeding the order executor
`default_nettype none
module boe_mem_model #(
  parameter int unsigned ADDR_W = 28
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Stall controls from the bench
  input  wire logic              hold,
  input  wire logic              slow,
  // List fetch
  input  wire logic              branchPulse,
  input  wire logic [ADDR_W-1:0] fetchAddr,
  output logic                   listValid,
  input  wire logic              listReady,
  output logic [15:0]            listData,
  // Row and write-back handshakes
  output logic                   rowReady,
  input  wire logic              wbValid,
  output logic                   wbReady,
  input  wire logic [ADDR_W-1:0] wbAddr,
  input  wire logic [15:0]       wbData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:127];
  logic [6:0]  ptr;
  logic        armed;
  logic        reload;

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
    listValid = 1'b0;
    listData = 16'h0000;
    rowReady = 1'b0;
    wbReady = 1'b0;
  end

  // Restart one idle cycle after a restart pulse, from the address the executor asks for
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr <= 7'h00;
      armed <= 1'b0;
      reload <= 1'b0;
    end else begin
      if (listValid && listReady) ptr <= ptr + 7'h01;
      if (branchPulse) begin
        armed <= 1'b1;
        reload <= 1'b1;
      end else if (reload) begin
        ptr <= fetchAddr[7:1];
        reload <= 1'b0;
      end
      if (wbValid && wbReady) mem[wbAddr[7:1]] <= wbData;
    end
  end

  // Outside a valid word the data lines keep moving, so no stale word can pass
  always @(negedge mclk) begin
    listValid <= armed && !reload;
    listData <= (armed && !reload) ? mem[ptr] : ~listData;
    rowReady <= !hold && (!slow || !rowReady);
    wbReady <= !slow || !wbReady;
  end
endmodule
`default_nettype wire

// ==== banded_order_executor_tb.sv ====
// Self-checking bench for the banded order executor
`default_nettype none
module banded_order_executor_tb;
  import boe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, start, hold, slow, running, haltPulse, branchPulse;
  logic [27:0] startAddr, fetchAddr, wbAddr;
  logic [7:0]  curBand, rowLogic, dispOpcode;
  logic        listValid, listReady, rowValid, rowReady, wbValid, wbReady;
  logic [15:0] listData, rowWidth, wbData;
  logic [31:0] rowAddr;
  logic        dispValid, dispReverse, dispWalkBack, dispNeedSrc, dispNeedHt;
  logic        bandFault, orderSkipped, badOpcode, sawFull;
  logic [55:0] rowQ[$];
  logic [11:0] dispQ[$];
  int          errorCnt, nCompared, nFault, nSkip, nHalt, nBad, wp, idx;

  banded_order_executor banded_order_executor_i (
    .mclk(mclk), .rst(rst), .start(start), .startAddr(startAddr), .curBand(curBand),
    .running(running), .haltPulse(haltPulse), .branchPulse(branchPulse), .fetchAddr(fetchAddr),
    .listValid(listValid), .listReady(listReady), .listData(listData),
    .rowValid(rowValid), .rowReady(rowReady), .rowAddr(rowAddr), .rowWidth(rowWidth), .rowLogic(rowLogic),
    .dispValid(dispValid), .dispOpcode(dispOpcode), .dispReverse(dispReverse), .dispWalkBack(dispWalkBack),
    .dispNeedSrc(dispNeedSrc), .dispNeedHt(dispNeedHt), .wbValid(wbValid), .wbReady(wbReady),
    .wbAddr(wbAddr), .wbData(wbData), .bandFault(bandFault), .orderSkipped(orderSkipped),
    .badOpcode(badOpcode));

  boe_mem_model boe_mem_model_i (
    .mclk(mclk), .rst(rst), .hold(hold), .slow(slow), .branchPulse(branchPulse), .fetchAddr(fetchAddr),
    .listValid(listValid), .listReady(listReady), .listData(listData), .rowReady(rowReady),
    .wbValid(wbValid), .wbReady(wbReady), .wbAddr(wbAddr), .wbData(wbData));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Event monitor feeding the scenario checks
  always @(posedge mclk) begin
    if (rowValid && rowReady) rowQ.push_back({rowLogic, rowWidth, rowAddr});
    if (dispValid) dispQ.push_back({dispOpcode, dispReverse, dispWalkBack, dispNeedSrc, dispNeedHt});
    if (bandFault) nFault++;
    if (orderSkipped) nSkip++;
    if (haltPulse) nHalt++;
    if (badOpcode) nBad++;
    if (!rst && !listReady) sawFull = 1'b1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [15:0] v);
    boe_mem_model_i.mem[wp] = v;
    wp++;
  endtask

  task automatic putl(input logic [31:0] v);
    put(v[31:16]);
    put(v[15:0]);
  endtask

  // Sliced map setup: offset, row pitch, band span, flags
  task automatic setup(input logic [31:0] off, input logic [31:0] pitch, input logic [31:0] span, input logic rev);
    wp = 0;
    put({OP_SET_SLICED, 8'h00});
    putl(off);
    putl(pitch);
    putl(span);
    put({15'h0000, rev});
  endtask

  task automatic go(input logic [7:0] band);
    rowQ.delete();
    dispQ.delete();
    nFault = 0;
    nSkip = 0;
    nHalt = 0;
    nBad = 0;
    curBand = band;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
  endtask

  task automatic wait_halt();
    for (int i = 0; i < 3000 && nHalt == 0; i++) @(negedge mclk);
    check(nHalt, 1);
    check(running, 1'b0);
  endtask

  // Down fill inside one band, with the row side stalled until the word buffer refuses
  task automatic t_fill();
    setup(32'hFFFF_F000, 32'h0000_0100, 32'h0001_0000, 1'b0);
    put({OP_SET_DEST_ONLY_LOGIC_CODE, 8'h00});
    put(16'h005A);
    put({OP_DEST_FILL, 8'h02});
    putl(32'h0000_1200);
    put(16'h0040);
    put(16'h0003);
    for (int i = 0; i < 24; i++) begin
      put({OP_SET_BOOL_HD, 8'h00});
      put(16'h0011);
    end
    put({OP_HALT, 8'h00});
    hold = 1'b1;
    sawFull = 1'b0;
    go(8'h02);
    repeat (80) @(negedge mclk);
    check(sawFull, 1'b1);
    check(rowQ.size(), 0);
    hold = 1'b0;
    wait_halt();
    check(rowQ.size(), 3);
    for (int i = 0; i < 3; i++) check(rowQ[i], {8'h5A, 16'h0040, 32'h0000_0200 + 32'h100 * i});
    check(nFault, 0);
    $display("test fill done");
  endtask

  // Reverse page: frame and scanline dispatch, skipped slice, fault walking upward
  task automatic t_reverse();
    setup(32'hFFFF_F000, 32'h0000_0100, 32'h0000_0400, 1'b1);
    // Expanded frame order always needs its source
    put({8'h16, 8'h00});
    repeat (8) put(16'h0000);
    // Scanline operands name the table end; contents are not fetched here
    put({8'h34, 8'h03});
    repeat (4) put(16'h0000);
    put({OP_DEST_FILL, 8'h07});
    putl(32'h0000_1100);
    put(16'h0020);
    put(16'h0001);
    idx = wp;
    put({OP_DEST_FILL, 8'h03});
    putl(32'h0000_1100);
    put(16'h0020);
    put(16'h0004);
    put({OP_HALT, 8'h00});
    go(8'h03);
    wait_halt();
    check(dispQ.size(), 2);
    check(dispQ[0], {8'h16, 1'b0, 1'b0, 1'b1, 1'b0});
    check(dispQ[1], {8'h34, 1'b1, 1'b1, 1'b0, 1'b0});
    check(nSkip, 1);
    check(nFault, 1);
    check(rowQ.size(), 2);
    check(rowQ[0][31:0], 32'h0000_0100);
    check(rowQ[1][31:0], 32'h0000_0000);
    check(boe_mem_model_i.mem[idx], {OP_DEST_FILL, 8'h02});
    check(boe_mem_model_i.mem[idx + 1], 16'h0000);
    check(boe_mem_model_i.mem[idx + 2], 16'h0F00);
    check(boe_mem_model_i.mem[idx + 3], 16'h0020);
    check(boe_mem_model_i.mem[idx + 4], 16'h0002);
    $display("test reverse done");
  endtask

  // Downward fault with slow row and write-back answers
  task automatic t_down_fault();
    setup(32'hFFFF_F000, 32'h0000_0100, 32'h0000_0400, 1'b0);
    put({OP_SET_DEST_ONLY_LOGIC_CODE, 8'h00});
    put(16'h0033);
    idx = wp;
    put({OP_DEST_FILL, 8'h05});
    putl(32'h0000_1200);
    put(16'h0010);
    put(16'h0005);
    put({OP_HALT, 8'h00});
    slow = 1'b1;
    go(8'h05);
    wait_halt();
    slow = 1'b0;
    check(nFault, 1);
    check(rowQ.size(), 2);
    check(rowQ[1], {8'h33, 16'h0010, 32'h0000_0300});
    check(boe_mem_model_i.mem[idx], {OP_DEST_FILL, 8'h06});
    check(boe_mem_model_i.mem[idx + 2], 16'h1400);
    check(boe_mem_model_i.mem[idx + 4], 16'h0003);
    $display("test down fault done");
  endtask

  // Branch past a halt onto an undefined opcode, which must halt with the error pulse
  task automatic t_branch();
    wp = 0;
    put({OP_BRANCH, 8'h00});
    putl(32'h0000_000A);
    put({OP_HALT, 8'h00});
    put(16'h0000);
    put({8'h02, 8'h00});
    go(8'h00);
    wait_halt();
    check(nBad, 1);
    $display("test branch done");
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    startAddr = 28'h0000000;
    curBand = 8'h00;
    hold = 1'b0;
    slow = 1'b0;
    sawFull = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_fill();
    t_reverse();
    t_down_fault();
    t_branch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
